/* File: logic/ptbc_defs.vh */
// register offsets, field positions and reset values of the time base counter
`ifndef PTBC_DEFS_VH
`define PTBC_DEFS_VH

`define PTBC_OFF_COUNT      5'h00
`define PTBC_OFF_CTRL       5'h04
`define PTBC_OFF_IRQ_STATUS 5'h08
`define PTBC_OFF_IRQ_MASK   5'h0c
`define PTBC_OFF_LOWPOWER   5'h10

`define PTBC_CS_OVF_BIT     5
`define PTBC_CS_IRQEN_BIT   4
`define PTBC_CS_EN_BIT      3
`define PTBC_CS_PSEL_HI     2
`define PTBC_CS_PSEL_LO     0

`define PTBC_LP_WAIT_BIT    0
`define PTBC_LP_HALT_BIT    1

`define PTBC_COUNT_RST      8'h00
`define PTBC_CTRL_RST       8'h00
`define PTBC_IRQEN_RST      1'b0
`define PTBC_EN_RST         1'b0
`define PTBC_PSEL_RST       3'h0
`define PTBC_MASK_RST       1'b0
`define PTBC_LP_RST         2'b00

`define PTBC_RESP_OKAY      2'b00
`define PTBC_RESP_SLVERR    2'b10

`endif

/* File: logic/ptbc_prescaler.v */
// prescaler: divider held at zero while run is low, with a one-cycle tick at the selected power of two
`timescale 1ns/1ps
module ptbc_prescaler (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       run,
    input  wire [2:0] prescale_select,
    output wire       tick
);
    reg  [7:0] div_q;
    wire [7:0] div_d;
    wire [7:0] last;

    // divide factor is 2 << select, so terminal count is that minus one
    assign last  = (8'h02 << prescale_select) - 8'h01;
    assign tick  = run && (div_q == last);
    assign div_d = (!run || tick) ? 8'h00 : div_q + 8'h01;

    always @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_d;
        end
    end
endmodule

/* File: logic/ptbc_counter.v */
// 8-bit up-counter with software load and wrap pulse
`timescale 1ns/1ps
`include "ptbc_defs.vh"
module ptbc_counter (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       tick,
    input  wire       load,
    input  wire [7:0] load_value,
    output reg  [7:0] count_value,
    output wire       wrap
);
    assign wrap = tick && !load && (count_value == 8'hff);

    always @(posedge aclk) begin
        if (!aresetn) begin
            count_value <= `PTBC_COUNT_RST;
        end else if (load) begin
            count_value <= load_value;
        end else if (tick) begin
            count_value <= count_value + 8'h01;
        end
    end
endmodule

/* File: logic/ptbc_time_base.v */
// time base unit: prescaled 8-bit counter with overflow flag behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "ptbc_defs.vh"
module ptbc_time_base (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [4:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [4:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        overflow_irq,
    output wire        irq
);
    reg  [4:0] awaddr_q;
    reg        aw_held_q;
    reg [31:0] wdata_q;
    reg        wstrb0_q;
    reg        w_held_q;
    reg        overflow_flag_q;
    reg        overflow_irq_enable_q;
    reg        count_enable_bit_q;
    reg  [2:0] prescale_select_q;
    reg        irq_status_q;
    reg        irq_mask_q;
    reg  [1:0] lowpower_q;
    wire [7:0] count_value;
    wire       tick;
    wire       wrap;
    wire       run;
    wire       wr_fire;
    wire       rd_fire;
    wire       wr_lane0;
    wire       rd_cs;
    wire [7:0] cs_read;
    wire [4:0] wr_word;
    wire [4:0] rd_word;
    reg        wsel_count;
    reg        wsel_ctrl;
    reg        wsel_status;
    reg        wsel_mask;
    reg        wsel_lowpower;
    reg        wsel_none;
    reg [31:0] rdata_d;
    reg  [1:0] rresp_d;

    // write channels are captured independently; response follows both
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign wr_lane0      = wr_fire && wstrb0_q;

    assign run = count_enable_bit_q && !lowpower_q[`PTBC_LP_HALT_BIT];
    assign wr_word = {awaddr_q[4:2], 2'b00};
    assign rd_word = {s_axi_araddr[4:2], 2'b00};
    assign rd_cs   = rd_fire && (rd_word == `PTBC_OFF_CTRL);

    assign cs_read = {2'b00, overflow_flag_q, overflow_irq_enable_q,
                      count_enable_bit_q, prescale_select_q};

    // write target from the held address; anything past the last register answers an error
    always @* begin
        wsel_count    = 1'b0;
        wsel_ctrl     = 1'b0;
        wsel_status   = 1'b0;
        wsel_mask     = 1'b0;
        wsel_lowpower = 1'b0;
        wsel_none     = 1'b0;
        case (wr_word)
            `PTBC_OFF_COUNT: begin
                wsel_count = 1'b1;
            end
            `PTBC_OFF_CTRL: begin
                wsel_ctrl = 1'b1;
            end
            `PTBC_OFF_IRQ_STATUS: begin
                wsel_status = 1'b1;
            end
            `PTBC_OFF_IRQ_MASK: begin
                wsel_mask = 1'b1;
            end
            `PTBC_OFF_LOWPOWER: begin
                wsel_lowpower = 1'b1;
            end
            default: begin
                wsel_none = 1'b1;
            end
        endcase
    end

    // read word for the address on the bus, latched when the read is taken
    always @* begin
        rdata_d = 32'h00000000;
        rresp_d = `PTBC_RESP_OKAY;
        case (rd_word)
            `PTBC_OFF_COUNT: begin
                rdata_d = {24'h000000, count_value};
            end
            `PTBC_OFF_CTRL: begin
                rdata_d = {24'h000000, cs_read};
            end
            `PTBC_OFF_IRQ_STATUS: begin
                rdata_d = {31'h00000000, irq_status_q};
            end
            `PTBC_OFF_IRQ_MASK: begin
                rdata_d = {31'h00000000, irq_mask_q};
            end
            `PTBC_OFF_LOWPOWER: begin
                rdata_d = {30'h00000000, lowpower_q};
            end
            default: begin
                rresp_d = `PTBC_RESP_SLVERR;
            end
        endcase
    end

    ptbc_prescaler u_prescaler (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .run             (run),
        .prescale_select (prescale_select_q),
        .tick            (tick)
    );

    ptbc_counter u_counter (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .tick        (tick),
        .load        (wr_lane0 && wsel_count),
        .load_value  (wdata_q[7:0]),
        .count_value (count_value),
        .wrap        (wrap)
    );

    assign overflow_irq = overflow_flag_q && overflow_irq_enable_q;
    assign irq          = irq_status_q && irq_mask_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            awaddr_q     <= 5'h00;
            wdata_q      <= 32'h00000000;
            wstrb0_q     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PTBC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wsel_none ? `PTBC_RESP_SLVERR : `PTBC_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            overflow_irq_enable_q <= `PTBC_IRQEN_RST;
            count_enable_bit_q    <= `PTBC_EN_RST;
            prescale_select_q     <= `PTBC_PSEL_RST;
            irq_mask_q            <= `PTBC_MASK_RST;
            lowpower_q            <= `PTBC_LP_RST;
        end else begin
            if (wr_lane0 && wsel_ctrl) begin
                // flag bit and bits 7:6 are not stored from the write
                overflow_irq_enable_q <= wdata_q[`PTBC_CS_IRQEN_BIT];
                count_enable_bit_q    <= wdata_q[`PTBC_CS_EN_BIT];
                prescale_select_q     <= wdata_q[`PTBC_CS_PSEL_HI:`PTBC_CS_PSEL_LO];
            end
            if (wr_lane0 && wsel_mask) begin
                irq_mask_q <= wdata_q[0];
            end
            if (wr_lane0 && wsel_lowpower) begin
                lowpower_q <= wdata_q[`PTBC_LP_HALT_BIT:`PTBC_LP_WAIT_BIT];
            end
        end
    end

    // set wins over both clears
    always @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag_q <= 1'b0;
            irq_status_q    <= 1'b0;
        end else begin
            if (wrap) begin
                overflow_flag_q <= 1'b1;
            end else if (rd_cs) begin
                overflow_flag_q <= 1'b0;
            end
            if (wrap) begin
                irq_status_q <= 1'b1;
            end else if (wr_lane0 && wsel_status && wdata_q[0]) begin
                irq_status_q <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `PTBC_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_d;
            s_axi_rresp  <= rresp_d;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* File: tb/ptbc_time_base_assertions.sv */
// port assertions for the time base unit
`timescale 1ns/1ps
module ptbc_time_base_assertions (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire [4:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        overflow_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire rt = s_axi_arvalid && s_axi_arready;
    wire rc = rt && s_axi_araddr == 5'h04;
    wire wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    chk_read_answer: assert property (rt |=> s_axi_rvalid)
        else $error("read not answered");
    chk_write_answer: assert property (wt |=> ##1 s_axi_bvalid)
        else $error("write not answered");
    chk_rdata_stands: assert property
        (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_write_refused: assert property
        (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    chk_read_refused: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read ready wrong");
    chk_unmapped_read: assert property
        (rt && s_axi_araddr[4:2] > 3'h4 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read answer wrong");
    chk_ctrl_high_zero: assert property (rc |=> s_axi_rdata[31:6] == 26'h0)
        else $error("control upper bits not zero");
    chk_flag_clear: assert property
        ($fell(overflow_irq) |-> $past(rc) || $past(rc, 2) || $rose(s_axi_bvalid))
        else $error("overflow request fell without cause");
    cover property (wt);
    cover property (rt && s_axi_araddr > 5'h10);
    cover property ($rose(overflow_irq));
endmodule
bind ptbc_time_base ptbc_time_base_assertions chk (.*);

/* File: tb/ptbc_time_base_bench.sv */
// self-checking bench for the time base unit
`timescale 1ns/1ps
module ptbc_time_base_bench;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        overflow_irq, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
    int          mismatches = 0, checks = 0, i;
    // address, write value, read value, response
    logic [22:0] rows [7] = '{{5'h00, 8'h5a, 8'h5a, 2'h0}, {5'h04, 8'he7, 8'h07, 2'h0},
        {5'h0c, 8'hff, 8'h01, 2'h0}, {5'h10, 8'h03, 8'h03, 2'h0}, {5'h10, 8'h00, 8'h00, 2'h0},
        {5'h14, 8'h3c, 8'h00, 2'h2}, {5'h04, 8'h00, 8'h00, 2'h0}};
    ptbc_time_base dut (.*);
    always #4 aclk = ~aclk;
    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        begin
            checks++;
            if (got !== exp) begin
                mismatches++;
                $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", checks, mismatches);
            if (mismatches == 0 && checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // waits, settled, for the condition k and returns on the edge that samples it
    task wt(input int k);
        begin
            #1;
            while (!(k == 0 ? s_axi_awready && s_axi_wready : k == 1 ? s_axi_bvalid :
                     k == 2 ? s_axi_arready : s_axi_rvalid)) begin
                @(posedge aclk);
                #1;
            end
            rd = s_axi_rdata;
            rr = s_axi_rresp;
            br = s_axi_bresp;
            @(posedge aclk);
        end
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            wt(0);
            s_axi_awvalid <= 1'h0;
            s_axi_wvalid <= 1'h0;
            wt(1);
            s_axi_bready <= 1'h1;
            wt(1);
            s_axi_bready <= 1'h0;
        end
    endtask
    task rdr(input logic [4:0] a);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            wt(2);
            s_axi_arvalid <= 1'h0;
            wt(3);
            s_axi_rready <= 1'h1;
            wt(3);
            s_axi_rready <= 1'h0;
        end
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        print_verdict;
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 7; i++) begin
            wr(rows[i][22:18], {24'h0, rows[i][17:10]});
            chk("bresp", br, rows[i][1:0]);
            rdr(rows[i][22:18]);
            chk("rdata", rd, rows[i][9:2]);
            chk("rresp", rr, rows[i][1:0]);
        end
        $display("register table done");
        wr(5'h00, 32'h0);
        for (i = 0; i < 8; i++) begin
            wr(5'h04, 32'h08 | i);
            repeat (3 * (2 << i) + (1 << i) - 5) @(posedge aclk);
            wr(5'h04, 32'h0);
            repeat (20) @(posedge aclk);
            rdr(5'h00);
            chk("count", rd, 3 * (i + 1));
        end
        $display("prescaler done");
        wr(5'h00, 32'hff);
        wr(5'h04, 32'h18);
        for (i = 0; i < 50 && overflow_irq !== 1'h1; i++) @(negedge aclk);
        chk("overflow req", overflow_irq, 1);
        chk("irq", irq, 1);
        wr(5'h04, 32'h08);
        chk("req disabled", overflow_irq, 0);
        wr(5'h04, 32'h18);
        chk("flag kept", overflow_irq, 1);
        rdr(5'h04);
        chk("ctrl", rd, 32'h38);
        chk("flag cleared", overflow_irq, 0);
        wr(5'h04, 32'h38);
        chk("flag not set", overflow_irq, 0);
        rdr(5'h08);
        chk("status", rd, 1);
        wr(5'h0c, 32'h0);
        chk("masked", irq, 0);
        wr(5'h0c, 32'h1);
        chk("unmasked", irq, 1);
        wr(5'h08, 32'h1);
        chk("status clear", irq, 0);
        $display("overflow done");
        wr(5'h10, 32'h02);
        wr(5'h00, 32'h40);
        wr(5'h04, 32'h08);
        repeat (40) @(posedge aclk);
        rdr(5'h00);
        chk("halted", rd, 32'h40);
        wr(5'h10, 32'h01);
        repeat (40) @(posedge aclk);
        rdr(5'h00);
        chk("wait runs", rd > 32'h40, 1);
        $display("low power done");
        aresetn <= 1'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rdr(5'h00);
        chk("count reset", rd, 0);
        rdr(5'h04);
        chk("ctrl reset", rd, 0);
        chk("irq reset", irq, 0);
        $display("reset done");
        wr(5'h00, 32'hff);
        wr(5'h04, 32'h0a);
        repeat (4) @(posedge aclk);
        rdr(5'h04);
        chk("read at wrap", rd, 32'h0a);
        rdr(5'h04);
        chk("flag survives", rd, 32'h2a);
        $display("coincident wrap done");
        print_verdict;
    end
endmodule
